// *** core/btc_timer.sv ***
// Buffered 16-bit timer/counter with AXI4-Lite register slave.
// Assumes compare units and converter drive trigger inputs on clk_sys.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`default_nettype none

module btc_timer import btc_pkg::*; #(
  parameter int INSTR_DIV = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        s_axi_awvalid,
  input  wire logic [5:0]  s_axi_awaddr,
  output logic             s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_wready,
  output logic             s_axi_bvalid,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic [5:0]  s_axi_araddr,
  output logic             s_axi_arready,
  output logic             s_axi_rvalid,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        s_axi_rready,
  input  wire logic        extClkPin,
  input  wire logic        auxOscClk,
  input  wire logic        cmpOneEvent,
  input  wire logic        cmpTwoEvent,
  output logic             overflowIrq,
  output logic             adcStart,
  output logic [15:0]      countValue
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    btc_regs_s   regs;
    logic [15:0] count;
    logic [7:0]  highBuf;
    logic [2:0]  prescale;
    logic [7:0]  instrDiv;
    logic        awHeld;
    logic [5:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
    logic        adc;
    logic        awRdy;
    logic        wRdy;
    logic        arRdy;
  } btc_state_s;

  btc_state_s st;
  btc_state_s next_st;

  logic extRise;
  logic auxRise;
  logic extUnsyncLevel;
  logic extUnsyncPrev;

  btc_sync_edge u_ext_sync (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .asyncIn   (extClkPin),
    .syncLevel (),
    .risePulse (extRise)
  );

  btc_sync_edge u_aux_sync (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .asyncIn   (auxOscClk),
    .syncLevel (),
    .risePulse (auxRise)
  );

  // ****************************************************************
  // Unsynchronised path: three flops, edge decoded combinationally one cycle ahead of the synchronised pulse
  // ****************************************************************
  logic rawS1;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rawS1          <= 1'b0;
      extUnsyncLevel <= 1'b0;
      extUnsyncPrev  <= 1'b0;
    end else begin
      rawS1          <= extClkPin;
      extUnsyncLevel <= rawS1;
      extUnsyncPrev  <= extUnsyncLevel;
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic       wrGo;
  logic       rdGo;
  logic       tick;
  logic       srcEdge;
  logic       prescDone;
  logic       trigReset;
  logic       oneUses;
  logic       twoUses;
  logic       wide;
  logic       wrLow;
  logic [7:0] wByte;
  logic [1:0] ps;

  always_comb begin
    next_st = st;
    wide    = st.regs.ctrl[CTRL_WIDE_BIT];
    ps      = st.regs.ctrl[CTRL_PS_HI:CTRL_PS_LO];
    wByte   = st.wData[7:0];
    wrGo    = st.awHeld & st.wHeld & ~st.bvalid;
    rdGo    = s_axi_arvalid & ~st.rvalid;
    wrLow   = wrGo & st.wStrb[0] & (st.awAddr == ADDR_COUNT_LOW);

    // AXI channel capture
    if (s_axi_awvalid && !st.awHeld) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wHeld) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Clock source and prescaler
    next_st.instrDiv = (st.instrDiv == 8'(INSTR_DIV - 1)) ? 8'h00
                     : st.instrDiv + 8'h01;
    if (!st.regs.ctrl[CTRL_SRC_BIT]) begin
      srcEdge = (st.instrDiv == 8'(INSTR_DIV - 1));
    end else if (st.regs.auxCtrl[AUX_OSC_EN_BIT]) begin
      srcEdge = auxRise;
    end else if (!st.regs.ctrl[CTRL_NOSYNC]) begin
      srcEdge = extRise;
    end else begin
      srcEdge = extUnsyncLevel & ~extUnsyncPrev;
    end
    prescDone = 1'b0;
    tick      = 1'b0;
    if (st.regs.ctrl[CTRL_ON_BIT] && srcEdge) begin
      prescDone = ({1'b0, st.prescale}
                  == ((4'h1 << ps) - 4'h1));
      next_st.prescale = prescDone ? 3'b000 : st.prescale + 3'b001;
      tick = prescDone;
    end

    // Special event trigger reset
    oneUses   = st.regs.ctrl[CTRL_CMP2_BIT];
    twoUses   = st.regs.ctrl[CTRL_CMP2_BIT] | st.regs.ctrl[CTRL_CMP1_BIT];
    trigReset = (cmpOneEvent & oneUses) | (cmpTwoEvent & twoUses);
    next_st.adc = cmpTwoEvent
                & st.regs.cmpCtrl[CMPC_ADC_EN];

    if (tick) begin
      next_st.count = st.count + 16'h0001;
      if (st.count == COUNT_ALL_ONES) begin
        next_st.regs.irqFlags[OVF_BIT] = 1'b1;
      end
    end
    if (trigReset) begin
      next_st.count = COUNT_ZERO;
      next_st.regs.irqFlags[OVF_BIT] =
        st.regs.irqFlags[OVF_BIT];
    end

    // Register write
    if (wrGo) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      if (st.wStrb[0]) begin
        unique case (st.awAddr)
          ADDR_COUNT_LOW: begin
            next_st.count[7:0] = wByte;
            next_st.prescale   = 3'b000;
            if (wide) begin
              next_st.count[15:8] = st.highBuf;
            end else begin
              next_st.count[15:8] = st.count[15:8];
            end
          end
          ADDR_COUNT_HIGH: begin
            if (wide) begin
              next_st.highBuf = wByte;
            end else begin
              next_st.count[15:8] = wByte;
              if (!trigReset) begin
                next_st.count[7:0] = tick ? st.count[7:0] + 8'h01
                                          : st.count[7:0];
              end
            end
          end
          ADDR_CTRL:        next_st.regs.ctrl = wByte;
          ADDR_AUX_CTRL:    next_st.regs.auxCtrl = wByte;
          ADDR_IRQ_FLAGS: begin
            next_st.regs.irqFlags = wByte;
            if (tick && st.count == COUNT_ALL_ONES && !trigReset) begin
              next_st.regs.irqFlags[OVF_BIT] = 1'b1;
            end
          end
          ADDR_IRQ_ENABLES: next_st.regs.irqEnables = wByte;
          ADDR_IRQ_PRIO:    next_st.regs.irqPrio = wByte;
          ADDR_INT_CTRL:    next_st.regs.intCtrl = wByte;
          ADDR_CMP_CTRL: begin
            if (st.wStrb[1]) begin
              next_st.regs.cmpCtrl = st.wData[8:0];
            end
          end
          default: next_st.bresp = RESP_SLVERR;
        endcase
      end
    end

    // Register read
    if (rdGo) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      next_st.rdata  = 32'h00000000;
      unique case (s_axi_araddr)
        ADDR_COUNT_LOW: begin
          next_st.rdata[7:0] = st.count[7:0];
          if (wide && !(wrLow)) begin
            next_st.highBuf = st.count[15:8];
          end
        end
        ADDR_COUNT_HIGH:
          next_st.rdata[7:0] = wide ? st.highBuf
                                    : st.count[15:8];
        ADDR_CTRL:        next_st.rdata[7:0] = st.regs.ctrl;
        ADDR_AUX_CTRL:    next_st.rdata[7:0] = st.regs.auxCtrl;
        ADDR_IRQ_FLAGS:   next_st.rdata[7:0] = st.regs.irqFlags;
        ADDR_IRQ_ENABLES: next_st.rdata[7:0] = st.regs.irqEnables;
        ADDR_IRQ_PRIO:    next_st.rdata[7:0] = st.regs.irqPrio;
        ADDR_INT_CTRL:    next_st.rdata[7:0] = st.regs.intCtrl;
        ADDR_CMP_CTRL:    next_st.rdata[8:0] = st.regs.cmpCtrl;
        default:          next_st.rresp = RESP_SLVERR;
      endcase
    end

    next_st.awRdy = ~next_st.awHeld;
    next_st.wRdy  = ~next_st.wHeld;
    next_st.arRdy = ~next_st.rvalid;
    next_st.irq = next_st.regs.irqFlags[OVF_BIT]
                & next_st.regs.irqEnables[OVF_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st       <= '0;
      st.awRdy <= 1'b1;
      st.wRdy  <= 1'b1;
      st.arRdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = st.awRdy;
  assign s_axi_wready  = st.wRdy;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arRdy;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign overflowIrq   = st.irq;
  assign adcStart      = st.adc;
  assign countValue    = st.count;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_wrap_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && !trigReset && !wrGo && st.count == COUNT_ALL_ONES
    |=> st.count == COUNT_ZERO) else $error("no wrap");
  a_ovf_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick && !trigReset && st.count == COUNT_ALL_ONES
    |=> st.regs.irqFlags[OVF_BIT]) else $error("flag lost");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !st.regs.irqEnables[OVF_BIT] |-> !st.irq)
    else $error("irq leaked");
  a_trig_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    trigReset && !wrGo |=> st.count == COUNT_ZERO)
    else $error("no trigger reset");
  a_trig_noflag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    trigReset && !wrGo && !st.regs.irqFlags[OVF_BIT]
    |=> !st.regs.irqFlags[OVF_BIT]) else $error("trig flag");
  a_write_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrLow && trigReset |=> st.count[7:0] == $past(wByte))
    else $error("write lost");
  a_frozen: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !st.regs.ctrl[CTRL_ON_BIT] && !trigReset && !wrGo
    |=> $stable(st.count)) else $error("count moved");
  a_wide_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrLow && wide |=> st.count[15:8] == $past(st.highBuf))
    else $error("high not loaded");
  a_high_presc: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrGo && st.awAddr == ADDR_COUNT_HIGH && !tick && !srcEdge
    |=> st.prescale == $past(st.prescale))
    else $error("prescale cleared");
  a_low_copy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rdGo && wide && s_axi_araddr == ADDR_COUNT_LOW && !wrGo
    |=> st.highBuf == $past(st.count[15:8]))
    else $error("buffer stale");

endmodule

`default_nettype wire

// *** core/btc_pkg.sv ***
// Constants, register map and state carriers for the buffered 16-bit timer.
// Assumes an AXI4-Lite master and on-chip compare units outside the block.
//
// What this block does
// - Wide mode maps high address to buffer
// - Low read copies live high into buffer
// - Low write loads high from buffer
// - Wide mode hides live high byte
// - Only low-byte writes clear the prescaler
// - Counter wraps all-ones to zero
// - Overflow sets flag bit 1 of flags
// - Flag forwarded only when enable bit set
// - Unit one trigger resets counter when ctrl bit 6 set, unit two when bit 6 or 3 set
// - Unit two trigger starts enabled conversion
// - Software write beats trigger reset
// - Trigger reset never sets overflow flag
// - Source select picks instruction or edges
// - Prescale codes divide by 1,2,4,8
// - Narrow mode gives independent byte access
// - Counter-on clear freezes the count
`default_nettype none

package btc_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [5:0] ADDR_COUNT_LOW   = 6'h00;
  localparam logic [5:0] ADDR_COUNT_HIGH  = 6'h04;
  localparam logic [5:0] ADDR_CTRL        = 6'h08;
  localparam logic [5:0] ADDR_AUX_CTRL    = 6'h0c;
  localparam logic [5:0] ADDR_IRQ_FLAGS   = 6'h10;
  localparam logic [5:0] ADDR_IRQ_ENABLES = 6'h14;
  localparam logic [5:0] ADDR_IRQ_PRIO    = 6'h18;
  localparam logic [5:0] ADDR_INT_CTRL    = 6'h1c;
  localparam logic [5:0] ADDR_CMP_CTRL    = 6'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_WIDE_BIT  = 7;
  localparam int CTRL_CMP2_BIT  = 6;
  localparam int CTRL_PS_HI     = 5;
  localparam int CTRL_PS_LO     = 4;
  localparam int CTRL_CMP1_BIT  = 3;
  localparam int CTRL_NOSYNC    = 2;
  localparam int CTRL_SRC_BIT   = 1;
  localparam int CTRL_ON_BIT    = 0;
  localparam int AUX_OSC_EN_BIT = 3;
  localparam int OVF_BIT        = 1;
  localparam int CMPC_ADC_EN    = 8;

  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  localparam logic [15:0] COUNT_ZERO     = 16'h0000;
  localparam logic [3:0]  MODE_SPECIAL   = 4'hb;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ****************************************************************
  // State carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] auxCtrl;
    logic [7:0] irqFlags;
    logic [7:0] irqEnables;
    logic [7:0] irqPrio;
    logic [7:0] intCtrl;
    logic [8:0] cmpCtrl;
  } btc_regs_s;

  typedef struct packed {
    logic        awvalid;
    logic [5:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [5:0]  araddr;
    logic        rready;
  } btc_axi_req_s;

endpackage

`default_nettype wire

// *** core/btc_sync_edge.sv ***
// Two-stage synchroniser with rising-edge pulse on the third stage.
// Assumes an asynchronous input level and one system clock.
`default_nettype none

module btc_sync_edge import btc_pkg::*; (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic asyncIn,
  output logic      syncLevel,
  output logic      risePulse
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } btc_sync_s;

  btc_sync_s st;
  btc_sync_s next_st;

  always_comb begin
    next_st      = st;
    next_st.s1   = asyncIn;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.rise = st.s2 & ~st.s3;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign syncLevel = st.s3;
  assign risePulse = st.rise;

endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the buffered 16-bit timer/counter.
// Assumes btc_timer with INSTR_DIV = 4 and one 20 MHz system clock.
`default_nettype none

module tb_top import btc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clkSys = 1'b0;
  logic        sysRst, awValid, awReady, wValid, wReady, bValid;
  logic        bReady, arValid, arReady, rValid, rReady, extClk, auxClk;
  logic        cmpOne, cmpTwo, ovfIrq, adcGo;
  logic [5:0]  awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [3:0]  wStrb;
  logic [1:0]  bResp, rResp;
  logic [15:0] count;
  int          fails, comparisons;

  btc_timer #(.INSTR_DIV(4)) dut_u (
    .clk_sys(clkSys), .sys_rst(sysRst),
    .s_axi_awvalid(awValid), .s_axi_awaddr(awAddr), .s_axi_awready(awReady),
    .s_axi_wvalid(wValid), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wready(wReady), .s_axi_bvalid(bValid), .s_axi_bresp(bResp),
    .s_axi_bready(bReady), .s_axi_arvalid(arValid), .s_axi_araddr(arAddr),
    .s_axi_arready(arReady), .s_axi_rvalid(rValid), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rready(rReady), .extClkPin(extClk),
    .auxOscClk(auxClk), .cmpOneEvent(cmpOne), .cmpTwoEvent(cmpTwo),
    .overflowIrq(ovfIrq), .adcStart(adcGo), .countValue(count));

  always #25 clkSys = ~clkSys;

  // ****************************************************************
  // Checks and verdict
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkNear(input string n, input int e, input logic [15:0] g);
    comparisons++;
    if ($isunknown(g) || int'(g) < e - 1 || int'(g) > e + 1) begin
      fails++;
      $display("unexpected %s: expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // AXI4-Lite master
  // ****************************************************************
  task automatic axiWr(input logic [5:0] a, input logic [31:0] d,
                       output logic [1:0] r);
    r = 2'h3;
    @(posedge clkSys);
    awValid <= 1'b1;
    awAddr  <= a;
    wValid  <= 1'b1;
    wData   <= d;
    bReady  <= 1'b1;
    forever begin
      @(posedge clkSys);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) begin
        r = bResp;
        bReady <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axiRd(input logic [5:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    r = 2'h3;
    d = 32'hx;
    @(posedge clkSys);
    arValid <= 1'b1;
    arAddr  <= a;
    rReady  <= 1'b1;
    forever begin
      @(posedge clkSys);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) begin
        d = rData;
        r = rResp;
        rReady <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWr(a, d, r);
    chk($sformatf("bresp %h", a), RESP_OKAY, r);
  endtask

  task automatic rdChk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axiRd(a, d, r);
    chk($sformatf("rresp %h", a), RESP_OKAY, r);
    chk($sformatf("rdata %h", a), e, d);
  endtask

  task automatic pulse(input bit two);
    @(posedge clkSys);
    if (two) cmpTwo <= 1'b1; else cmpOne <= 1'b1;
    @(posedge clkSys);
    cmpOne <= 1'b0;
    cmpTwo <= 1'b0;
  endtask

  task automatic edges(input bit aux, input int n);
    repeat (n) begin
      @(posedge clkSys);
      if (aux) auxClk <= 1'b1; else extClk <= 1'b1;
      repeat (5) @(posedge clkSys);
      auxClk <= 1'b0;
      extClk <= 1'b0;
      repeat (5) @(posedge clkSys);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic testResetMap();
    logic [31:0] d;
    logic [1:0]  r;
    rdChk(ADDR_CTRL, 32'h0);
    rdChk(ADDR_IRQ_FLAGS, 32'h0);
    chk("count", 32'h0, {16'h0, count});
    axiRd(6'h3c, d, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    axiWr(6'h24, 32'hff, r);
    chk("unmapped bresp", RESP_SLVERR, r);
  endtask

  task automatic testBytes();
    wr(ADDR_COUNT_HIGH, 32'h12);
    wr(ADDR_COUNT_LOW, 32'h34);
    chk("narrow count", 32'h1234, {16'h0, count});
    rdChk(ADDR_COUNT_HIGH, 32'h12);
    wr(ADDR_CTRL, 32'h80);
    wr(ADDR_COUNT_HIGH, 32'hab);
    chk("buffered high", 32'h1234, {16'h0, count});
    wr(ADDR_COUNT_LOW, 32'hcd);
    chk("wide write", 32'habcd, {16'h0, count});
    wr(ADDR_COUNT_HIGH, 32'h55);
    rdChk(ADDR_COUNT_LOW, 32'hcd);
    rdChk(ADDR_COUNT_HIGH, 32'hab);
    wr(ADDR_CTRL, 32'h00);
  endtask

  task automatic testPrescale();
    logic [15:0] snap;
    wr(ADDR_COUNT_HIGH, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_COUNT_LOW, 32'h0);
      wr(ADDR_CTRL, 32'h01 | (p << 4));
      repeat (40 << p) @(posedge clkSys);
      wr(ADDR_CTRL, p << 4);
      snap = count;
      chkNear("prescaled ticks", 10, count);
      repeat (100) @(posedge clkSys);
      chk("frozen count", {16'h0, snap}, {16'h0, count});
    end
  endtask

  task automatic testOverflow();
    wr(ADDR_COUNT_HIGH, 32'hff);
    wr(ADDR_COUNT_LOW, 32'hfe);
    wr(ADDR_CTRL, 32'h01);
    repeat (40) @(posedge clkSys);
    wr(ADDR_CTRL, 32'h00);
    chkNear("wrapped count", 8, count);
    rdChk(ADDR_IRQ_FLAGS, 32'h02);
    chk("masked irq", 32'h0, {31'h0, ovfIrq});
    wr(ADDR_IRQ_ENABLES, 32'h02);
    repeat (2) @(posedge clkSys);
    chk("enabled irq", 32'h1, {31'h0, ovfIrq});
    wr(ADDR_IRQ_FLAGS, 32'h00);
    repeat (2) @(posedge clkSys);
    rdChk(ADDR_IRQ_FLAGS, 32'h00);
    chk("cleared irq", 32'h0, {31'h0, ovfIrq});
  endtask

  task automatic testTrigger();
    wr(ADDR_COUNT_HIGH, 32'h10);
    wr(ADDR_COUNT_LOW, 32'h00);
    wr(ADDR_CTRL, 32'h41);
    pulse(1'b0);
    repeat (2) @(posedge clkSys);
    chkNear("trigger reset", 0, count);
    rdChk(ADDR_IRQ_FLAGS, 32'h00);
    wr(ADDR_CTRL, 32'h09);
    wr(ADDR_COUNT_HIGH, 32'h20);
    wr(ADDR_COUNT_LOW, 32'h00);
    pulse(1'b0);
    repeat (2) @(posedge clkSys);
    chkNear("unit one ignored", 16'h2002, count);
    pulse(1'b1);
    repeat (2) @(posedge clkSys);
    chkNear("unit two reset", 0, count);
    wr(ADDR_CTRL, 32'h00);
  endtask

  task automatic testConversion();
    wr(ADDR_CMP_CTRL, 32'h100);
    pulse(1'b1);
    #1 chk("conversion start", 32'h1, {31'h0, adcGo});
    wr(ADDR_CMP_CTRL, 32'h000);
    pulse(1'b1);
    #1 chk("converter off", 32'h0, {31'h0, adcGo});
  endtask

  task automatic testExternal();
    wr(ADDR_COUNT_HIGH, 32'h0);
    wr(ADDR_COUNT_LOW, 32'h0);
    wr(ADDR_CTRL, 32'h03);
    edges(1'b0, 5);
    chk("external edges", 32'h5, {16'h0, count});
    wr(ADDR_CTRL, 32'h07);
    edges(1'b0, 2);
    chk("unsynced edges", 32'h7, {16'h0, count});
    wr(ADDR_AUX_CTRL, 32'h08);
    edges(1'b1, 3);
    edges(1'b0, 2);
    chk("aux edges", 32'ha, {16'h0, count});
    wr(ADDR_CTRL, 32'h00);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    sysRst = 1'b1; awValid = 1'b0; awAddr = 6'h0;
    wValid = 1'b0; wData = 32'h0; wStrb = 4'hf; bReady = 1'b0;
    arValid = 1'b0; arAddr = 6'h0; rReady = 1'b0; extClk = 1'b0;
    auxClk = 1'b0; cmpOne = 1'b0; cmpTwo = 1'b0;
    fails = 0; comparisons = 0;
    repeat (6) @(posedge clkSys);
    sysRst <= 1'b0;
    testResetMap();
    testBytes();
    testPrescale();
    testOverflow();
    testTrigger();
    testConversion();
    testExternal();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clkSys);
    fails++;
    stop_test();
  end
endmodule

`default_nettype wire
